// *** core/tpo_pkg.sv ***
/*
 Constants, codes and register map of the trigger pulse output block.
 Assumes a 25 MHz ref_clk and a 32-bit classic Wishbone slave port.
*/
package tpo_pkg;
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          TICK_US       = 40;
   localparam int          TICK_CYC      = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam logic [31:0] US_PER_TICK   = 32'h0000_0028;

   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_OUTSEL = 8'h04;
   localparam logic [7:0] OFS_SRC    = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0C;
   localparam logic [7:0] OFS_WIDTH  = 8'h10;
   localparam logic [7:0] OFS_SDELAY = 8'h14;
   localparam logic [7:0] OFS_SWIDTH = 8'h18;
   localparam logic [7:0] OFS_PDELAY = 8'h1C;
   localparam logic [7:0] OFS_PWIDTH = 8'h20;
   localparam logic [7:0] OFS_PHALF  = 8'h24;
   localparam logic [7:0] OFS_COUNT  = 8'h28;
   localparam logic [7:0] OFS_FORCE  = 8'h2C;
   localparam logic [7:0] OFS_STATUS = 8'h30;

   localparam int SRC_ENC_BIT  = 0;
   localparam int SRC_SEC3_BIT = 1;

   localparam logic [6:0]  RST_MODE   = 7'h00;
   localparam logic [3:0]  RST_OUTSEL = 4'h1;
   localparam logic [21:0] RST_PERIOD = 22'h00_0019;

   localparam logic [6:0] MODE_PERIODIC_HI = 7'h64;
   localparam logic [6:0] MODE_PERIODIC_LO = 7'h65;
   localparam logic [6:0] MODE_FORCE_HI    = 7'h66;
   localparam logic [6:0] MODE_FORCE_LO    = 7'h67;
   localparam logic [6:0] MODE_REACHED_LO  = 7'h69;

   localparam logic [1:0] GRP_STANDARD = 2'h0;
   localparam logic [1:0] GRP_PWIDTH   = 2'h1;
   localparam logic [1:0] GRP_PDELAY   = 2'h2;
   localparam logic [1:0] GRP_PFREQ    = 2'h3;

   typedef enum logic [2:0] {
      SEC_IDLE   = 3'b001,
      SEC_DELAY  = 3'b010,
      SEC_ACTIVE = 3'b100
   } tpo_sec_e;

   typedef struct packed {
      logic        wbAck;
      logic [31:0] wbDat;
      logic [6:0]  mode;
      logic [3:0]  outSel;
      logic        encSel;
      logic        sec3;
      logic [21:0] widthTk;
      logic [21:0] sDelayTk;
      logic [21:0] sWidthTk;
      logic [21:0] periodTk;
      logic [31:0] pDelay;
      logic [31:0] pWidth;
      logic [31:0] pHalf;
      logic [30:0] count;
      logic [9:0]  tickCnt;
      logic [21:0] perCnt;
      logic        priOn;
      logic [21:0] priCnt;
      tpo_sec_e    sec;
      logic [31:0] secCnt;
      logic [31:0] freqCnt;
      logic        freqLvl;
      logic [31:0] trigPos;
      logic        primOut;
      logic        secOut;
   } tpo_state_s;
endpackage

// *** core/tpo_trigger_pulse_outputs.sv ***
/*
 Trigger pulse generator: primary and secondary outputs, periodic and
 forced triggers, event counter, precise secondary modes, Wishbone regs.
 Assumes position, encoder state and position events come from logic on
 ref_clk; external instruments sit behind the two trigger outputs.
*/
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module tpo_trigger_pulse_outputs
   import tpo_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [31:0] motorPos,
   input  wire logic [31:0] encoderPos,
   input  wire logic        encodersActive,
   input  wire logic        posTrigEvent,
   output logic      [31:0] trigPos,
   output logic             primary_output,
   output logic             secondary_output
);
   tpo_state_s q;
   tpo_state_s d;

   logic        tick;
   logic        lowActive;
   logic        fire;
   logic        forceReq;
   logic        busReq;
   logic        doWrite;
   logic [31:0] rdVal;
   logic [31:0] wrVal;
   logic [1:0]  grp;
   logic        priAct;
   logic        secAct;

   function automatic logic [31:0] laneMerge(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = oldV;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = newV[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [21:0] toTicks(input logic [31:0] us);
      logic [31:0] t;
      t = us / US_PER_TICK;
      return t[21:0];
   endfunction

   function automatic logic [31:0] toUs(input logic [21:0] tk);
      logic [53:0] p;
      p = {32'h0000_0000, tk} * {22'h00_0000, US_PER_TICK};
      return p[31:0];
   endfunction

   always_comb begin
      d = q;
      tick = (q.tickCnt == 10'(TICK_CYC - 1));
      grp = q.outSel[3:2];
      lowActive = (q.mode >= 7'h03 && q.mode <= 7'h05) ||
                  (q.mode >= 7'h09 && q.mode <= 7'h0B) ||
                  q.mode == MODE_PERIODIC_LO ||
                  q.mode == MODE_FORCE_LO ||
                  q.mode == MODE_REACHED_LO;
      busReq = cyc_i && stb_i;
      doWrite = busReq && we_i && q.wbAck;

      rdVal = 32'h0000_0000;
      if (adr_i == OFS_MODE) begin
         rdVal = {25'h000_0000, q.mode};
      end else if (adr_i == OFS_OUTSEL) begin
         rdVal = {28'h000_0000, q.outSel};
      end else if (adr_i == OFS_SRC) begin
         rdVal = {30'h0000_0000, q.sec3, q.encSel};
      end else if (adr_i == OFS_PERIOD) begin
         rdVal = {10'h000, q.periodTk};
      end else if (adr_i == OFS_WIDTH) begin
         rdVal = toUs(q.widthTk);
      end else if (adr_i == OFS_SDELAY) begin
         rdVal = toUs(q.sDelayTk);
      end else if (adr_i == OFS_SWIDTH) begin
         rdVal = toUs(q.sWidthTk);
      end else if (adr_i == OFS_PDELAY) begin
         rdVal = q.pDelay;
      end else if (adr_i == OFS_PWIDTH) begin
         rdVal = q.pWidth;
      end else if (adr_i == OFS_PHALF) begin
         rdVal = q.pHalf;
      end else if (adr_i == OFS_COUNT) begin
         rdVal = {1'b0, q.count};
      end else if (adr_i == OFS_STATUS) begin
         rdVal = {27'h000_0000, q.sec == SEC_DELAY,
                  encodersActive && q.encSel, q.priOn,
                  q.secOut, q.primOut};
      end
      wrVal = laneMerge(rdVal, dat_i, sel_i);

      // answer one cycle after the request, drop in the next
      d.wbAck = busReq && !q.wbAck;
      if (busReq && !q.wbAck) begin
         d.wbDat = rdVal;
      end

      forceReq = 1'b0;
      if (doWrite) begin
         if (adr_i == OFS_MODE) begin
            d.mode = wrVal[6:0];
         end else if (adr_i == OFS_OUTSEL) begin
            d.outSel = wrVal[3:0];
         end else if (adr_i == OFS_SRC) begin
            d.encSel = wrVal[SRC_ENC_BIT];
            d.sec3   = wrVal[SRC_SEC3_BIT];
         end else if (adr_i == OFS_PERIOD) begin
            d.periodTk = wrVal[21:0];
         end else if (adr_i == OFS_WIDTH) begin
            d.widthTk = toTicks(wrVal);
         end else if (adr_i == OFS_SDELAY) begin
            d.sDelayTk = toTicks(wrVal);
         end else if (adr_i == OFS_SWIDTH) begin
            d.sWidthTk = toTicks(wrVal);
         end else if (adr_i == OFS_PDELAY) begin
            d.pDelay = wrVal;
         end else if (adr_i == OFS_PWIDTH) begin
            d.pWidth = wrVal;
         end else if (adr_i == OFS_PHALF) begin
            d.pHalf = wrVal;
         end else if (adr_i == OFS_FORCE) begin
            forceReq = wrVal[0] && sel_i[0];
         end
      end

      // fall back to motor while encoders are inactive
      d.trigPos = (q.encSel && encodersActive) ? encoderPos : motorPos;

      d.tickCnt = tick ? 10'h000 : q.tickCnt + 10'h001;

      // periodic source, counted in 40us ticks
      fire = 1'b0;
      if (q.mode == MODE_PERIODIC_HI || q.mode == MODE_PERIODIC_LO) begin
         if (tick) begin
            if (q.perCnt == 22'h00_0000) begin
               d.perCnt = (q.periodTk == 22'h00_0000) ? 22'h00_0000 :
                          q.periodTk - 22'h00_0001;
               fire = 1'b1;
            end else begin
               d.perCnt = q.perCnt - 22'h00_0001;
            end
         end
      end else begin
         d.perCnt = 22'h00_0000;
         if (q.mode == MODE_FORCE_HI || q.mode == MODE_FORCE_LO) begin
            fire = forceReq;
         end else begin
            fire = posTrigEvent;
         end
      end

      // primary pulse; zero width leaves a single-cycle spike
      if (fire) begin
         d.priOn  = 1'b1;
         d.priCnt = q.widthTk;
      end else if (q.priOn) begin
         if (q.priCnt == 22'h00_0000) begin
            d.priOn = 1'b0;
         end else if (tick) begin
            d.priCnt = q.priCnt - 22'h00_0001;
         end
      end

      // counter wraps past its 31-bit range; a software write wins
      if (fire) begin
         d.count = q.count + 31'h0000_0001;
      end
      if (doWrite && adr_i == OFS_COUNT) begin
         d.count = wrVal[30:0];
      end

      // secondary sequencer; precise groups pick width or delay, standard with sec3 runs delay then width
      case (q.sec)
         SEC_IDLE: begin
            if (fire && grp == GRP_PWIDTH) begin
               d.sec    = SEC_ACTIVE;
               d.secCnt = q.pWidth;
            end else if (fire && grp == GRP_PDELAY) begin
               d.sec    = SEC_DELAY;
               d.secCnt = q.pDelay;
            end else if (fire && grp == GRP_STANDARD && q.sec3) begin
               d.sec    = SEC_DELAY;
               d.secCnt = {10'h000, q.sDelayTk};
            end
         end
         SEC_DELAY: begin
            if (grp == GRP_PDELAY) begin
               if (q.secCnt == 32'h0000_0000) begin
                  d.sec = SEC_ACTIVE;
               end else begin
                  d.secCnt = q.secCnt - 32'h0000_0001;
               end
            end else if (!q.priOn) begin
               d.sec = SEC_IDLE;
            end else if (tick) begin
               if (q.secCnt == 32'h0000_0000) begin
                  d.sec    = SEC_ACTIVE;
                  d.secCnt = {10'h000, q.sWidthTk};
               end else begin
                  d.secCnt = q.secCnt - 32'h0000_0001;
               end
            end
         end
         SEC_ACTIVE: begin
            if (grp == GRP_PDELAY) begin
               if (tick) begin
                  d.sec = SEC_IDLE;
               end
            end else if (grp == GRP_PWIDTH) begin
               if (q.secCnt == 32'h0000_0000) begin
                  d.sec = SEC_IDLE;
               end else begin
                  d.secCnt = q.secCnt - 32'h0000_0001;
               end
            end else if (!q.priOn) begin
               d.sec = SEC_IDLE;
            end else if (tick) begin
               if (q.secCnt == 32'h0000_0000) begin
                  d.sec = SEC_IDLE;
               end else begin
                  d.secCnt = q.secCnt - 32'h0000_0001;
               end
            end
         end
         default: begin
            d.sec = SEC_IDLE;
         end
      endcase
      if (q.sec != SEC_IDLE && fire && grp != GRP_PFREQ) begin
         // a new trigger restarts the secondary sequence
         d.sec    = (grp == GRP_PWIDTH) ? SEC_ACTIVE : SEC_DELAY;
         d.secCnt = (grp == GRP_PWIDTH) ? q.pWidth :
                    (grp == GRP_PDELAY) ? q.pDelay :
                    {10'h000, q.sDelayTk};
         if (grp == GRP_STANDARD && !q.sec3) begin
            d.sec = SEC_IDLE;
         end
      end

      // free-running square wave, toggled every half period
      if (grp != GRP_PFREQ || q.pHalf == 32'h0000_0000) begin
         d.freqCnt = 32'h0000_0000;
         d.freqLvl = 1'b0;
      end else if (q.freqCnt >= q.pHalf - 32'h0000_0001) begin
         d.freqCnt = 32'h0000_0000;
         d.freqLvl = !q.freqLvl;
      end else begin
         d.freqCnt = q.freqCnt + 32'h0000_0001;
      end

      priAct = d.priOn;
      case (grp)
         GRP_STANDARD: begin
            secAct = q.sec3 ? (d.sec == SEC_ACTIVE && d.priOn) :
                     d.priOn;
         end
         GRP_PFREQ: begin
            secAct = d.freqLvl;
         end
         default: begin
            secAct = (d.sec == SEC_ACTIVE);
         end
      endcase

      // shared polarity; unselected output sits at inactive level
      d.primOut = (q.outSel[0] && priAct) ^ lowActive;
      d.secOut  = (q.outSel[1] && secAct) ^ lowActive;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q          <= '0;
         q.mode     <= RST_MODE;
         q.outSel   <= RST_OUTSEL;
         q.periodTk <= RST_PERIOD;
         q.sec      <= SEC_IDLE;
      end else begin
         q <= d;
      end
   end

   assign dat_o            = q.wbDat;
   assign ack_o            = q.wbAck;
   assign trigPos          = q.trigPos;
   assign primary_output   = q.primOut;
   assign secondary_output = q.secOut;
endmodule

// *** testbench/tpo_trigger_pulse_outputs_assertions.sv ***
/*
 Port checker of the trigger pulse block, with shadows of the setup.
 Assumes whole-word register writes over classic Wishbone.
*/
`timescale 1ns/1ns
module tpo_trigger_pulse_outputs_assertions
   import tpo_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic [31:0] motorPos,
   input wire logic [31:0] encoderPos,
   input wire logic        encodersActive,
   input wire logic [31:0] trigPos,
   input wire logic        primary_output,
   input wire logic        secondary_output
);
   logic [6:0]  mode_q;
   logic [3:0]  osel_q;
   logic [31:0] pdly_q;
   logic [31:0] expPos_q;
   logic        enc_q;
   logic        wZero_q;
   logic        ackd_q;
   logic        wr;
   logic        lo;
   logic        pa;
   logic        sa;
   assign wr = cyc_i && stb_i && we_i && ack_o;
   assign lo = mode_q inside {7'h03, 7'h04, 7'h05, 7'h09, 7'h0A, 7'h0B,
                              7'h65, 7'h67, 7'h69};
   assign pa = primary_output ^ lo;
   assign sa = secondary_output ^ lo;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_q   <= RST_MODE;
         osel_q   <= RST_OUTSEL;
         enc_q    <= 1'b0;
         wZero_q  <= 1'b1;
         pdly_q   <= 32'h0;
         ackd_q   <= 1'b0;
         expPos_q <= 32'h0;
      end else begin
         // setup reaches the pins two edges after the ack
         ackd_q   <= ack_o;
         expPos_q <= (enc_q && encodersActive) ? encoderPos : motorPos;
         if (wr && adr_i == OFS_MODE) mode_q <= dat_i[6:0];
         if (wr && adr_i == OFS_OUTSEL) osel_q <= dat_i[3:0];
         if (wr && adr_i == OFS_SRC) enc_q <= dat_i[0];
         if (wr && adr_i == OFS_WIDTH) wZero_q <= dat_i < 32'h28;
         if (wr && adr_i == OFS_PDELAY) pdly_q <= dat_i;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_src; trigPos == expPos_q; endproperty
   a_src: assert property (p_src) else $error("position source");
   property p_pidle; !ackd_q && !osel_q[0] |-> !pa; endproperty
   a_pidle: assert property (p_pidle) else $error("primary on");
   property p_sidle; !ackd_q && !osel_q[1] |-> !sa; endproperty
   a_sidle: assert property (p_sidle) else $error("secondary on");
   property p_copy; !ackd_q && osel_q == 4'h3 |-> sa == pa; endproperty
   a_copy: assert property (p_copy) else $error("no copy");
   property p_spike; !ackd_q && wZero_q && $rose(pa) |=> !pa; endproperty
   a_spike: assert property (p_spike) else $error("spike width");
   property p_force; wr && adr_i == OFS_FORCE && dat_i[0] && osel_q[0]
      && mode_q inside {7'h66, 7'h67} |-> ##1 pa; endproperty
   a_force: assert property (p_force) else $error("no forced pulse");
   property p_pdelay; !ackd_q && osel_q == 4'hB && pdly_q == 32'h2
      && $rose(pa) |-> !sa ##3 sa; endproperty
   a_pdelay: assert property (p_pdelay) else $error("delay");
   property p_pwidth; !ackd_q && osel_q == 4'h7 && $rose(pa) |-> sa;
   endproperty
   a_pwidth: assert property (p_pwidth) else $error("width start");
endmodule
bind tpo_trigger_pulse_outputs tpo_trigger_pulse_outputs_assertions tpo_chk (
   .ref_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .ack_o, .motorPos,
   .encoderPos, .encodersActive, .trigPos, .primary_output, .secondary_output);

// *** testbench/tpo_instrument.sv ***
/*
 Instrument model behind both outputs: counts pulses and active cycles.
 Assumes the bench tells it the active level of the current mode.
*/
`timescale 1ns/1ns
module tpo_instrument (
   input wire logic ref_clk,
   input wire logic lowAct,
   input wire logic priIn,
   input wire logic secIn,
   output int       priEdges = 0,
   output int       priHigh = 0,
   output int       secEdges = 0,
   output int       secHigh = 0
);
   logic pLast;
   logic sLast;
   // sampled mid-cycle, clear of the launch edge
   always @(negedge ref_clk) begin
      if ((priIn ^ lowAct) && !pLast) priEdges++;
      if ((secIn ^ lowAct) && !sLast) secEdges++;
      if (priIn ^ lowAct) priHigh++;
      if (secIn ^ lowAct) secHigh++;
      pLast = priIn ^ lowAct;
      sLast = secIn ^ lowAct;
   end
endmodule

// *** testbench/tpo_trigger_pulse_outputs_bench.sv ***
/*
 Bench of the trigger pulse block: setup over Wishbone, forced, position
 and periodic triggers, every output select code.
 Assumes the instrument model and the bound checker.
*/
`timescale 1ns/1ns
`define CHK(n, e, v) begin testsRun++; if ((v) !== (e)) begin failures++; \
   $display("wrong value %s exp %0h seen %0h", n, e, v); end end
module tpo_trigger_pulse_outputs_bench
   import tpo_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] motorPos = 32'h0;
   logic [31:0] encoderPos = 32'h0;
   logic        encodersActive = 1'b1;
   logic        posTrigEvent = 1'b0;
   logic        lowAct = 1'b0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic [31:0] trigPos;
   logic        primary_output;
   logic        secondary_output;
   int          failures = 0;
   int          testsRun = 0;
   int          pe;
   int          ph;
   int          se;
   int          sh;
   tpo_trigger_pulse_outputs tpo_trigger_pulse_outputs_inst (
      .ref_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i,
      .dat_o, .ack_o, .motorPos, .encoderPos, .encodersActive,
      .posTrigEvent, .trigPos, .primary_output, .secondary_output);
   tpo_instrument tpo_instrument_inst (.ref_clk, .lowAct,
      .priIn(primary_output), .secIn(secondary_output), .priEdges(pe),
      .priHigh(ph), .secEdges(se), .secHigh(sh));
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      // ack seen mid-cycle, answer taken at the edge that samples it
      do begin
         @(negedge ref_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      @(posedge ref_clk);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      if (n >= 50) begin
         failures++;
         wrapUp;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      `CHK(nm, e, r)
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic look;
      tick(5);
      @(negedge ref_clk);
   endtask
   task automatic lag(output int pi, output int si);
      pi = -1;
      si = -1;
      wr(OFS_FORCE, 32'h1);
      for (int i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         if (pi < 0 && (primary_output ^ lowAct)) pi = i;
         if (si < 0 && (secondary_output ^ lowAct)) si = i;
      end
   endtask
   task automatic t_regs;
      rd("mode", OFS_MODE, 32'h0);
      rd("outsel", OFS_OUTSEL, 32'h1);
      rd("period", OFS_PERIOD, 32'h19);
      wr(8'h3C, 32'h5);
      rd("unmapped", 8'h3C, 32'h0);
      wr(OFS_WIDTH, 32'h64);
      rd("width", OFS_WIDTH, 32'h50);
      wr(OFS_WIDTH, 32'h0);
      $display("registers done");
   endtask
   task automatic t_src;
      @(posedge ref_clk);
      motorPos   <= 32'h1111_1111;
      encoderPos <= 32'h2222_2222;
      look;
      `CHK("motor", 32'h1111_1111, trigPos)
      wr(OFS_SRC, 32'h1);
      look;
      `CHK("encoder", 32'h2222_2222, trigPos)
      @(posedge ref_clk);
      encodersActive <= 1'b0;
      look;
      `CHK("noEncoder", 32'h1111_1111, trigPos)
      encodersActive <= 1'b1;
      $display("source done");
   endtask
   task automatic t_force;
      int p0;
      int s0;
      int h0;
      wr(OFS_MODE, 32'h66);
      wr(OFS_OUTSEL, 32'h3);
      wr(OFS_COUNT, 32'h6E);
      p0 = pe;
      s0 = se;
      h0 = ph;
      wr(OFS_FORCE, 32'h1);
      look;
      `CHK("forced", 1, pe - p0)
      `CHK("copied", 1, se - s0)
      `CHK("spike", 1, ph - h0)
      rd("count", OFS_COUNT, 32'h6F);
      lowAct <= 1'b1;
      wr(OFS_MODE, 32'h67);
      look;
      `CHK("idleHigh", 1'b1, secondary_output)
      p0 = pe;
      wr(OFS_FORCE, 32'h1);
      look;
      `CHK("forcedLow", 1, pe - p0)
      lowAct <= 1'b0;
      wr(OFS_MODE, 32'h0);
      look;
      p0 = pe;
      wr(OFS_FORCE, 32'h1);
      look;
      `CHK("ignored", 0, pe - p0)
      @(posedge ref_clk);
      posTrigEvent <= 1'b1;
      @(posedge ref_clk);
      posTrigEvent <= 1'b0;
      look;
      rd("posCount", OFS_COUNT, 32'h71);
      wr(OFS_MODE, 32'h66);
      $display("force done");
   endtask
   task automatic t_codes;
      int p0;
      int s0;
      for (int c = 0; c < 16; c++) begin
         wr(OFS_OUTSEL, 32'(c));
         // long gap lets a delayed secondary pulse clear
         tick(1000);
         p0 = pe;
         s0 = se;
         wr(OFS_FORCE, 32'h1);
         look;
         `CHK("priSel", int'(c[0]), pe - p0)
         `CHK("secSel", int'(c[1] && c < 12), se - s0)
      end
      wr(OFS_PHALF, 32'h3);
      s0 = se;
      p0 = sh;
      tick(60);
      `CHK("duty", 30, sh - p0)
      `CHK("freq", 10, se - s0)
      // 0x71 after the force test, plus sixteen forced pulses
      rd("noCount", OFS_COUNT, 32'h81);
      wr(OFS_PHALF, 32'h0);
      $display("codes done");
   endtask
   task automatic t_prec;
      int pi;
      int si;
      int h0;
      wr(OFS_OUTSEL, 32'hB);
      wr(OFS_PDELAY, 32'h2);
      tick(1000);
      lag(pi, si);
      `CHK("delay", 3, si - pi)
      tick(1000);
      @(negedge ref_clk);
      `CHK("cleared", 1'b0, secondary_output)
      wr(OFS_OUTSEL, 32'h7);
      wr(OFS_PWIDTH, 32'h4);
      tick(1000);
      h0 = sh;
      lag(pi, si);
      `CHK("start", 0, si - pi)
      `CHK("pwidth", 5, sh - h0)
      $display("precise done");
   endtask
   task automatic t_std;
      int h0;
      int s0;
      wr(OFS_OUTSEL, 32'h2);
      wr(OFS_SRC, 32'h3);
      wr(OFS_WIDTH, 32'hC8);
      wr(OFS_SDELAY, 32'h28);
      wr(OFS_SWIDTH, 32'h64);
      rd("sdelay", OFS_SDELAY, 32'h28);
      rd("swidth", OFS_SWIDTH, 32'h50);
      h0 = sh;
      s0 = se;
      wr(OFS_FORCE, 32'h1);
      // own width of two ticks spans three tick boundaries
      tick(7000);
      `CHK("ownEdges", 1, se - s0)
      `CHK("ownWidth", 3000, sh - h0)
      wr(OFS_WIDTH, 32'h0);
      wr(OFS_SRC, 32'h1);
      $display("standard done");
   endtask
   task automatic t_per;
      int p0;
      wr(OFS_OUTSEL, 32'h1);
      wr(OFS_PERIOD, 32'h1);
      wr(OFS_MODE, 32'h64);
      tick(1100);
      p0 = pe;
      tick(3000);
      `CHK("periodic", 3, pe - p0)
      wr(OFS_PERIOD, 32'h2);
      tick(2100);
      p0 = pe;
      tick(4000);
      `CHK("reload", 2, pe - p0)
      wr(OFS_MODE, 32'h66);
      $display("periodic done");
   endtask
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      failures++;
      wrapUp;
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs;
      t_src;
      t_force;
      t_codes;
      t_prec;
      t_std;
      t_per;
      wrapUp;
   end
endmodule
